// ===== hw/gpp_port.sv
/*
 sixteen pin general purpose port: per-pin mode, bus read and write.
 assumes an external converter delivers tagged 12-bit samples and
 pin levels are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_port
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // single pin control
  input wire logic i_mode_we,
  input wire logic [3:0] i_pin_sel,
  input wire gpp_pkg::gpp_mode_e i_mode,
  input wire logic i_bit_we,
  input wire logic i_bit_val,
  // bus access
  input wire logic i_bus_we,
  input wire gpp_pkg::gpp_word_t i_bus_wdata,
  output var gpp_pkg::gpp_word_t o_bus_rdata,
  // analog samples
  input wire gpp_pkg::gpp_adc_s i_adc,
  output var logic [4*`GPP_ADC_BITS-1:0] o_analog,
  // general_io_pins
  input wire gpp_pkg::gpp_word_t i_general_io_pins,
  output var gpp_pkg::gpp_word_t o_general_io_pins,
  output var gpp_pkg::gpp_word_t o_general_io_pins_oe,
  output var logic [`GPP_NANALOG-1:0] o_analog_en
);
  import gpp_pkg::*;

  gpp_word_t dir_r;
  gpp_word_t out_r;
  gpp_word_t sync1_r;
  gpp_word_t sync2_r;
  logic [`GPP_NANALOG-1:0] ana_r;
  logic [`GPP_ADC_BITS-1:0] samp_r [`GPP_NANALOG];
  gpp_word_t out_nxt;

  // mode per pin; analog request on upper pins falls back to input
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_r <= `GPP_DIR_RESET;
      ana_r <= '0;
    end else if (i_mode_we) begin
      dir_r[i_pin_sel] <= (i_mode == GPP_DOUT);
      if (i_pin_sel < 4'(`GPP_NANALOG)) begin
        ana_r[i_pin_sel[1:0]] <= (i_mode == GPP_AIN);
      end
      // upper pins have no analog flag to set
    end
  end

  always_comb begin
    out_nxt = out_r;
    if (i_bus_we) begin
      out_nxt = i_bus_wdata;
    end
    if (i_bit_we) begin
      out_nxt[i_pin_sel] = i_bit_val;
    end
  end

  // latch is written even while input, so output starts at a known level
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_r <= `GPP_OUT_RESET;
    end else begin
      out_r <= out_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_general_io_pins;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < `GPP_NANALOG; i++) begin
        samp_r[i] <= '0;
      end
    end else if (i_adc.valid && ana_r[i_adc.chan]) begin
      samp_r[i_adc.chan] <= i_adc.value;
    end
  end

  // pin drivers and readback, all registered
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_general_io_pins <= '0;
      o_general_io_pins_oe <= '0;
      o_bus_rdata <= '0;
      o_analog <= '0;
      o_analog_en <= '0;
    end else begin
      o_general_io_pins <= out_nxt;
      o_general_io_pins_oe <= dir_r;
      // output pins read back their own latch, input pins the pin
      o_bus_rdata <= (dir_r & out_r) | (~dir_r & sync2_r);
      o_analog_en <= ana_r;
      for (int i = 0; i < `GPP_NANALOG; i++) begin
        o_analog[i*`GPP_ADC_BITS +: `GPP_ADC_BITS] <= samp_r[i];
      end
    end
  end

  property p_oe_follows_dir;
    @(posedge i_clk) disable iff (!i_resetn)
      1 |=> o_general_io_pins_oe == $past(dir_r);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("output enable differs from pin direction");

  property p_bus_write;
    @(posedge i_clk) disable iff (!i_resetn)
      i_bus_we && !i_bit_we |=> o_general_io_pins == $past(i_bus_wdata);
  endproperty
  a_bus_write: assert property (p_bus_write)
    else $error("bus write not driven on pins");

  property p_bit_write;
    @(posedge i_clk) disable iff (!i_resetn)
      i_bit_we |=> o_general_io_pins[$past(i_pin_sel)] == $past(i_bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write)
    else $error("single pin write lost");

  property p_upper_no_analog;
    @(posedge i_clk) disable iff (!i_resetn)
      i_mode_we && i_pin_sel >= 4'(`GPP_NANALOG) |=> ana_r == $past(ana_r);
  endproperty
  a_upper_no_analog: assert property (p_upper_no_analog)
    else $error("upper pin changed analog state");

  property p_analog_set;
    @(posedge i_clk) disable iff (!i_resetn)
      i_mode_we && i_mode == GPP_AIN && i_pin_sel < 4'(`GPP_NANALOG)
      |=> ##1 o_analog_en[$past(i_pin_sel[1:0], 2)];
  endproperty
  a_analog_set: assert property (p_analog_set)
    else $error("analog mode not taken");

  // synchroniser still holds reset zeros one edge after release
  property p_input_read;
    @(posedge i_clk) disable iff (!i_resetn)
      $past(i_resetn) |=> ##1
      (o_bus_rdata & ~$past(dir_r)) ==
      ($past(i_general_io_pins, 3) & ~$past(dir_r));
  endproperty
  a_input_read: assert property (p_input_read)
    else $error("input readback wrong");

  property p_sample_held;
    @(posedge i_clk) disable iff (!i_resetn)
      i_adc.valid && ana_r[i_adc.chan] |=> ##1
      o_analog[$past(i_adc.chan, 2)*`GPP_ADC_BITS +: `GPP_ADC_BITS]
      == $past(i_adc.value, 2);
  endproperty
  a_sample_held: assert property (p_sample_held)
    else $error("analog sample not returned");

  property p_reset_inputs;
    @(posedge i_clk) !i_resetn |=> o_general_io_pins_oe == '0;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("driver enabled after reset");

  property p_reset_modes;
    @(posedge i_clk)
      !i_resetn |=> o_analog_en == '0 && o_general_io_pins == '0;
  endproperty
  a_reset_modes: assert property (p_reset_modes)
    else $error("analog mode or drive level left after reset");

  property p_ain_input;
    @(posedge i_clk) disable iff (!i_resetn)
      i_mode_we && i_mode == GPP_AIN |=> !dir_r[$past(i_pin_sel)];
  endproperty
  a_ain_input: assert property (p_ain_input)
    else $error("analog request left a driver on");

  property p_digital_clears_analog;
    @(posedge i_clk) disable iff (!i_resetn)
      i_mode_we && i_mode != GPP_AIN && i_pin_sel < 4'(`GPP_NANALOG)
      |=> !ana_r[$past(i_pin_sel[1:0])];
  endproperty
  a_digital_clears_analog: assert property (p_digital_clears_analog)
    else $error("digital mode kept analog flag");

  property p_aen_follows;
    @(posedge i_clk) disable iff (!i_resetn)
      1 |=> o_analog_en == $past(ana_r);
  endproperty
  a_aen_follows: assert property (p_aen_follows)
    else $error("analog enable differs from pin mode");

  // refused samples must leave the held reading alone
  property p_sample_refused;
    @(posedge i_clk) disable iff (!i_resetn)
      i_adc.valid && !ana_r[i_adc.chan]
      |=> samp_r[$past(i_adc.chan)] == $past(samp_r[i_adc.chan]);
  endproperty
  a_sample_refused: assert property (p_sample_refused)
    else $error("sample taken on non-analog pin");

  c_bus_write: cover property (@(posedge i_clk) i_bus_we);
  c_analog: cover property (@(posedge i_clk) |o_analog_en);
  c_mixed: cover property (@(posedge i_clk)
    (dir_r != '0) && (dir_r != '1));
  c_sample_taken: cover property (@(posedge i_clk)
    i_adc.valid && ana_r[i_adc.chan]);
  c_bit_over_bus: cover property (@(posedge i_clk)
    i_bus_we && i_bit_we);
endmodule : gpp_port
`default_nettype wire

// ===== hw/gpp_consts.svh
/*
 gpio port constants: pin counts, sample width, reset values.
 assumes inclusion by the port package and top module only.
*/
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_NPINS 16
`define GPP_NANALOG 4
`define GPP_ADC_BITS 12
`define GPP_DIR_RESET 16'h0000
`define GPP_OUT_RESET 16'h0000
`endif

// ===== hw/gpp_pkg.sv
/*
 types for the sixteen pin port.
 assumes gpp_consts.svh is on the include path.
*/
`include "gpp_consts.svh"
package gpp_pkg;
  typedef enum logic [1:0] {
    GPP_DIN,
    GPP_DOUT,
    GPP_AIN
  } gpp_mode_e;
  typedef logic [`GPP_NPINS-1:0] gpp_word_t;
  typedef struct packed {
    logic [`GPP_ADC_BITS-1:0] value;
    logic [1:0] chan;
    logic valid;
  } gpp_adc_s;
endpackage : gpp_pkg

// ===== tb/gpp_pin_model.sv
/* far side of the port: external levels, overridden where the port drives.
 assumes one clock domain and no pin contention. */
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model
  import gpp_pkg::*;
(
  // port side
  input wire gpp_pkg::gpp_word_t i_drive,
  input wire gpp_pkg::gpp_word_t i_oe,
  // board side
  input wire gpp_pkg::gpp_word_t i_ext,
  output var gpp_pkg::gpp_word_t o_pins
);
  // a driven pin shows the driven level, never the board's
  assign o_pins = (i_oe & i_drive) | (~i_oe & i_ext);
endmodule : gpp_pin_model
`default_nettype wire

// ===== tb/tb_gpp_port.sv
/* bench for gpp_port: mode, bit, bus and converter sequences.
 assumes gpp_pkg, gpp_port and gpp_pin_model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_gpp_port;
  import gpp_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_mode_we = 1'b0;
  logic i_bit_we = 1'b0, i_bit_val = 1'b0, i_bus_we = 1'b0;
  logic [3:0] i_pin_sel = 4'h0, aen;
  gpp_mode_e i_mode = GPP_DIN;
  gpp_word_t i_bus_wdata = 16'h0000, rd, po, oe, pins;
  gpp_word_t ext = 16'h5A5A;
  gpp_adc_s i_adc = '0;
  logic [47:0] ana;
  int miscompares = 0, checks_done = 0;
  always #2 i_clk = ~i_clk;
  gpp_port DUT(.i_clk(i_clk), .i_resetn(i_resetn), .i_mode_we(i_mode_we),
    .i_pin_sel(i_pin_sel), .i_mode(i_mode), .i_bit_we(i_bit_we),
    .i_bit_val(i_bit_val), .i_bus_we(i_bus_we), .i_bus_wdata(i_bus_wdata),
    .o_bus_rdata(rd), .i_adc(i_adc), .o_analog(ana),
    .i_general_io_pins(pins), .o_general_io_pins(po),
    .o_general_io_pins_oe(oe), .o_analog_en(aen));
  gpp_pin_model pm(.i_drive(po), .i_oe(oe), .i_ext(ext), .o_pins(pins));
  task tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tk
  task chk(input logic [99:0] s, input logic [99:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task mode(input logic [3:0] p, input gpp_mode_e m);
    @(posedge i_clk);
    i_pin_sel <= p;
    i_mode <= m;
    i_mode_we <= 1'b1;
    @(posedge i_clk);
    i_mode_we <= 1'b0;
    tk(2);
  endtask : mode
  task wr(input logic bw, input gpp_word_t d, input logic tw,
    input logic [3:0] p, input logic v);
    @(posedge i_clk);
    i_bus_we <= bw;
    i_bus_wdata <= d;
    i_bit_we <= tw;
    i_pin_sel <= p;
    i_bit_val <= v;
    @(posedge i_clk);
    i_bus_we <= 1'b0;
    i_bit_we <= 1'b0;
    #1;
  endtask : wr
  task adc(input logic [1:0] c, input logic [11:0] v);
    @(posedge i_clk);
    i_adc <= '{value: v, chan: c, valid: 1'b1};
    @(posedge i_clk);
    i_adc <= '0;
    tk(2);
  endtask : adc
  task test_done;
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk(100'({ana, aen, oe, po, rd}), 100'(0));
    tk(3);
    chk(100'(rd), 100'(16'h5A5A));
    wr(1'b1, 16'hC3A5, 1'b0, 4'h0, 1'b0);
    chk(100'(po), 100'(16'hC3A5));
    wr(1'b0, 16'h0000, 1'b1, 4'hF, 1'b0);
    chk(100'({oe, po}), 100'({16'h0000, 16'h43A5}));
    wr(1'b1, 16'h0F07, 1'b1, 4'h4, 1'b1);
    chk(100'(po), 100'(16'h0F17));
    mode(4'h3, GPP_DOUT);
    chk(100'(oe), 100'(16'h0008));
    chk(100'(rd), 100'(16'h5A52));
    @(posedge i_clk);
    ext <= 16'hA5A5;
    tk(2);
    chk(100'(rd), 100'(16'h5A52));
    tk(1);
    chk(100'(rd), 100'(16'hA5A5));
    mode(4'h0, GPP_AIN);
    chk(100'(aen), 100'(4'h1));
    adc(2'h0, 12'hABC);
    adc(2'h1, 12'h123);
    chk(100'(ana), 100'({36'h0, 12'hABC}));
    mode(4'h5, GPP_DOUT);
    chk(100'(oe), 100'(16'h0028));
    mode(4'h5, GPP_AIN);
    chk(100'({aen, oe}), 100'({4'h1, 16'h0008}));
    mode(4'h0, GPP_DOUT);
    chk(100'({aen, oe}), 100'({4'h0, 16'h0009}));
    mode(4'h3, GPP_DIN);
    chk(100'(oe), 100'(16'h0001));
    @(posedge i_clk);
    i_resetn <= 1'b0;
    #1;
    chk(100'({ana, aen, oe, po, rd}), 100'(0));
    @(posedge i_clk);
    i_resetn <= 1'b1;
    tk(3);
    chk(100'(rd), 100'(16'hA5A5));
    test_done();
  end
endmodule : tb_gpp_port
`default_nettype wire
